// [dv/serial_receive_control_tb.sv]
// Register-level testbench for the serial receive control block
module serial_receive_control_tb
    import src_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
    logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic rx_char_valid, rx_char_frame_err, serial_port_enable, nine_bit_receive_select, receive_run;
    logic single_receive_active, transmit_run, irq;
    logic [8:0] rx_char_data;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    src_serial_receive_control uut (.*);
    src_rx_far far (.*);
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end
    task automatic results;
        if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY,
                      input logic [3:0] st = 4'hf);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // Each channel is released at the edge that takes it
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask
    task automatic rc(input logic [4:0] a, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, e});
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(ADDR_CTRL, 8'h00);
        rc(5'h14, 8'h00, RESP_SLVERR);
        wr(ADDR_IMASK, 8'h0f);
        wr(ADDR_CTRL, 8'h90);
        far.send(9'h1a5, 1'b1);
        rc(ADDR_CTRL, 8'h94);
        chk({31'h0, irq}, 32'h1);
        rc(ADDR_DATA, 8'ha5);
        wr(ADDR_CTRL, 8'hd0);
        far.send(9'h13c, 1'b0);
        rc(ADDR_CTRL, 8'hd1);
        far.send(9'h0aa, 1'b0);
        rc(ADDR_CTRL, 8'hd3);
        chk({31'h0, receive_run}, 32'h0);
        wr(ADDR_CTRL, 8'hd0);
        rc(ADDR_CTRL, 8'hd3);
        wr(ADDR_CTRL, 8'hc0);
        rc(ADDR_CTRL, 8'hc1);
        rc(ADDR_ISTAT, 8'h07);
        wr(ADDR_IMASK, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_ISTAT, 8'h07);
        rc(ADDR_ISTAT, 8'h00);
        rc(ADDR_DATA, 8'h3c);
        wr(ADDR_MODE, 8'h07);
        wr(ADDR_CTRL, 8'h80);
        chk({31'h0, transmit_run}, 32'h1);
        wr(ADDR_CTRL, 8'h90);
        chk({31'h0, transmit_run}, 32'h0);
        wr(ADDR_CTRL, 8'ha0);
        chk({31'h0, transmit_run}, 32'h0);
        chk({31'h0, single_receive_active}, 32'h1);
        far.send(9'h033, 1'b1);
        rc(ADDR_CTRL, 8'h84);
        rc(ADDR_ISTAT, 8'h0b);
        far.send(9'h044, 1'b0);
        rc(ADDR_DATA, 8'h33);
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_CTRL, 8'ha0);
        chk({31'h0, receive_run}, 32'h0);
        // Async 9-bit address detect drops characters whose ninth bit is clear
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_CTRL, 8'hd8);
        chk({31'h0, nine_bit_receive_select}, 32'h1);
        chk({31'h0, serial_port_enable}, 32'h1);
        far.send(9'h055, 1'b0);
        rc(ADDR_CTRL, 8'hdc);
        far.send(9'h1c3, 1'b0);
        rc(ADDR_CTRL, 8'hd9);
        rc(ADDR_DATA, 8'hc3);
        // Lane 0 off, data register and unmapped writes change nothing
        wr(ADDR_CTRL, 8'h00, RESP_OKAY, 4'he);
        wr(ADDR_DATA, 8'h77);
        wr(5'h14, 8'h00, RESP_SLVERR);
        rc(ADDR_CTRL, 8'hd9);
        rc(ADDR_DATA, 8'hc3);
        wr(ADDR_IMASK, 8'h08);
        chk({31'h0, irq}, 32'h1);
        // Reset in mid-run returns CTRL, IMASK and ISTAT to zero
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(ADDR_CTRL, 8'h00);
        rc(ADDR_IMASK, 8'h00);
        rc(ADDR_ISTAT, 8'h00);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, serial_port_enable}, 32'h0);
        chk({31'h0, receive_run}, 32'h0);
        results();
    end
endmodule // serial_receive_control_tb

// [dv/src_rx_far.sv]
// Shift-path model that hands finished characters to the block
module src_rx_far
    import src_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Character out
    output logic rx_char_valid,
    output logic [8:0] rx_char_data,
    output logic rx_char_frame_err
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_char_valid = 1'b0;
        rx_char_data = 9'h0;
        rx_char_frame_err = 1'b0;
    end
    // One-cycle pulse; data is scrambled afterwards so stale values are never trusted
    task automatic send(input logic [8:0] d, input logic fe);
        rx_char_valid <= 1'b1;
        rx_char_data <= d;
        rx_char_frame_err <= fe;
        @(posedge aclk);
        rx_char_valid <= 1'b0;
        rx_char_data <= ~d;
        rx_char_frame_err <= ~fe;
    endtask
endmodule // src_rx_far

// [dv/src_serial_receive_control_assertions.sv]
// Bus handshake and receive control assertions
module src_rx_chk
    import src_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    // Receive side
    input wire logic rx_char_valid,
    input wire logic serial_port_enable,
    input wire logic receive_run,
    input wire logic single_receive_active,
    input wire logic transmit_run
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    endsequence
    sequence single_done;
        single_receive_active && rx_char_valid && !s_axi_awvalid;
    endsequence
    write_answer_a: assert property (wr_take |=> s_axi_bvalid)
        else $error("write not answered");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read not answered");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    rx_over_tx_a: assert property (single_receive_active |-> !transmit_run)
        else $error("transmit runs during single receive");
    single_clear_a: assert property (single_done |=> !single_receive_active)
        else $error("single receive not cleared");
    run_stop_a: assert property ($fell(receive_run) |-> $past(rx_char_valid) || $past(s_axi_awvalid))
        else $error("reception stopped without cause");
    enable_write_a: assert property ($changed(serial_port_enable) |-> $past(s_axi_awvalid))
        else $error("port enable changed without write");
endmodule // src_rx_chk
bind src_serial_receive_control src_rx_chk chk (.*);

// [hdl/src_axil_slave.sv]
// AXI4-Lite slave that turns bus transfers into register access strobes
module src_axil_slave
    import src_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    src_reg_if.bus rif
);
    typedef struct packed {
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [DATA_W-1:0] rdata;
    } src_axil_state_t;

    src_axil_state_t s_r;
    src_axil_state_t s_nxt;
    logic wr_go;
    logic rd_go;

    // Both write channels are taken in one edge, only with no response pending
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_r.bvalid;
    assign rd_go = s_axi_arvalid & ~s_r.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign rif.wr_en = wr_go;
    assign rif.wr_addr = s_axi_awaddr;
    assign rif.wdata = s_axi_wdata;
    assign rif.wstrb = s_axi_wstrb;
    assign rif.rd_en = rd_go;
    assign rif.rd_addr = s_axi_araddr;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rdata = s_r.rdata;

    always_comb begin
        s_nxt = s_r;
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (rd_go) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
            s_nxt.rdata = rif.rdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : src_axil_slave

// [hdl/src_pkg.sv]
// Shared constants and types for the serial receive control block
package src_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_ISTAT = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_IMASK = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 5'h10;
    // receive_status_control bit positions
    localparam int B_SERIAL_PORT_ENABLE = 7;
    localparam int B_RX9 = 6;
    localparam int B_SINGLE_RECEIVE_ENABLE = 5;
    localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int B_ADDRESS_DETECT_ENABLE = 3;
    localparam int B_FRAMING_ERROR_FLAG = 2;
    localparam int B_OVERRUN_ERROR_FLAG = 1;
    localparam int B_NINTH_RECEIVED_BIT = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hf8;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Interrupt status and mask bit positions
    localparam int I_RXB = 0;
    localparam int I_FRAMING_ERROR_FLAG = 1;
    localparam int I_OVERRUN_ERROR_FLAG = 2;
    localparam int I_SDONE = 3;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
    // Mode register bit positions
    localparam int M_SYNC = 0;
    localparam int M_MASTER = 1;
    localparam int M_TRANSMIT_ENABLE = 2;
    localparam int MODE_W = 3;
    localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : src_pkg

// [hdl/src_reg_if.sv]
// Register access path between the bus slave and the register file
interface src_reg_if;
    import src_pkg::*;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wr_hit;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rdata;
    logic rd_hit;
    modport bus (output wr_en, wr_addr, wdata, wstrb, rd_en, rd_addr, input wr_hit, rdata, rd_hit);
    modport regs (input wr_en, wr_addr, wdata, wstrb, rd_en, rd_addr, output wr_hit, rdata, rd_hit);
endinterface : src_reg_if

// [hdl/src_serial_receive_control.sv]
// Receive status and control register file of the serial port
//
// Notes on behaviour
// - In sync mode receive enables override transmit
// - Single receive runs once, then self-clears
// - Framing flag read-only, follows each byte loaded into the holding register
// - Overrun flag holds until continuous enable cleared
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
module src_serial_receive_control
    import src_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Received characters from the shift path
    input wire logic rx_char_valid,
    input wire logic [8:0] rx_char_data,
    input wire logic rx_char_frame_err,
    // Controls to the shift path and transmitter
    output logic serial_port_enable,
    output logic nine_bit_receive_select,
    output logic receive_run,
    output logic single_receive_active,
    output logic transmit_run,
    // Interrupt
    output logic irq
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rx_data;
        logic rx_full;
        logic [IRQ_W-1:0] istat;
        logic [IRQ_W-1:0] imask;
        logic [MODE_W-1:0] mode;
    } src_state_t;

    src_state_t s_r;
    src_state_t s_nxt;
    src_reg_if rif ();

    // Mode and enable decode
    logic sync_mode;
    logic single_receive_enable_eff;
    logic rx_claims_line;
    logic rx_run;
    logic rx_take;
    logic data_pop;

    // Receive events
    logic rx_accept;
    logic single_done;
    logic rx_overrun;
    logic rx_load;
    logic [IRQ_W-1:0] istat_set;

    // Write strobes
    logic wr_low;
    logic wr_ctrl;
    logic wr_istat;
    logic wr_imask;
    logic wr_mode;
    logic [7:0] ctrl_wr_val;

    src_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rif(rif.bus)
    );

    assign sync_mode = s_r.mode[M_SYNC];
    // Single receive only counts in sync master mode, and continuous receive overrides it
    assign single_receive_enable_eff = sync_mode & s_r.mode[M_MASTER] & s_r.ctrl[B_SINGLE_RECEIVE_ENABLE] & ~s_r.ctrl[B_CONTINUOUS_RECEIVE_ENABLE];
    // A pending overrun stops reception until continuous receive is turned off
    assign rx_run = s_r.ctrl[B_SERIAL_PORT_ENABLE] & ~s_r.ctrl[B_OVERRUN_ERROR_FLAG]
                    & (sync_mode ? (s_r.ctrl[B_CONTINUOUS_RECEIVE_ENABLE] | single_receive_enable_eff) : s_r.ctrl[B_CONTINUOUS_RECEIVE_ENABLE]);
    // Address detect drops data characters in async 9-bit mode
    assign rx_take = ~(~sync_mode & s_r.ctrl[B_RX9] & s_r.ctrl[B_ADDRESS_DETECT_ENABLE] & ~rx_char_data[8]);
    assign data_pop = rif.rd_en & (rif.rd_addr == ADDR_DATA);

    // A character counts only while reception runs
    assign rx_accept = rx_char_valid & rx_run;
    assign single_done = rx_accept & single_receive_enable_eff;
    // A full holding register not emptied in this cycle loses the new byte
    assign rx_overrun = rx_accept & rx_take & s_r.rx_full & ~data_pop;
    // Dropped and lost characters never reach the holding register
    assign rx_load = rx_accept & rx_take & ~rx_overrun;
    // Interrupt sources, one per event
    assign istat_set[I_RXB] = rx_load;
    assign istat_set[I_FRAMING_ERROR_FLAG] = rx_load & rx_char_frame_err;
    assign istat_set[I_OVERRUN_ERROR_FLAG] = rx_overrun;
    assign istat_set[I_SDONE] = single_done;

    // Every register sits in byte lane 0, so lane 0 gates every write
    assign wr_low = rif.wr_en & rif.wstrb[0];
    assign wr_ctrl = wr_low & (rif.wr_addr == ADDR_CTRL);
    assign wr_istat = wr_low & (rif.wr_addr == ADDR_ISTAT);
    assign wr_imask = wr_low & (rif.wr_addr == ADDR_IMASK);
    assign wr_mode = wr_low & (rif.wr_addr == ADDR_MODE);
    // Read-only control bits never take the bus value
    assign ctrl_wr_val = rif.wdata[7:0] & CTRL_WMASK;

    // Register read mux
    always_comb begin
        rif.rdata = '0;
        rif.rd_hit = 1'b1;
        unique case (rif.rd_addr)
            ADDR_CTRL: rif.rdata = {24'h000000, s_r.ctrl};
            ADDR_DATA: rif.rdata = {24'h000000, s_r.rx_data};
            ADDR_ISTAT: rif.rdata = {28'h0000000, s_r.istat};
            ADDR_IMASK: rif.rdata = {28'h0000000, s_r.imask};
            ADDR_MODE: rif.rdata = {29'h0, s_r.mode};
            default: rif.rd_hit = 1'b0;
        endcase
    end

    assign rif.wr_hit = (rif.wr_addr == ADDR_CTRL) | (rif.wr_addr == ADDR_DATA) | (rif.wr_addr == ADDR_ISTAT)
                        | (rif.wr_addr == ADDR_IMASK) | (rif.wr_addr == ADDR_MODE);

    always_comb begin
        s_nxt = s_r;
        // Reading the data register frees the holding register
        if (data_pop) begin
            s_nxt.rx_full = 1'b0;
        end
        // Completion of a single reception clears its enable before software writes
        if (single_done) begin
            s_nxt.ctrl[B_SINGLE_RECEIVE_ENABLE] = 1'b0;
        end

        // Software writes
        if (wr_ctrl) begin
            s_nxt.ctrl = (s_nxt.ctrl & ~CTRL_WMASK) | ctrl_wr_val;
            if (!rif.wdata[B_CONTINUOUS_RECEIVE_ENABLE]) begin
                s_nxt.ctrl[B_OVERRUN_ERROR_FLAG] = 1'b0;
            end
        end
        // Status bits clear where a one is written
        if (wr_istat) begin
            s_nxt.istat = s_r.istat & ~rif.wdata[IRQ_W-1:0];
        end
        if (wr_imask) begin
            s_nxt.imask = rif.wdata[IRQ_W-1:0];
        end
        if (wr_mode) begin
            s_nxt.mode = rif.wdata[MODE_W-1:0];
        end

        // Hardware events come last so a set wins over a clear in the same cycle
        s_nxt.istat = s_nxt.istat | istat_set;
        if (rx_overrun) begin
            s_nxt.ctrl[B_OVERRUN_ERROR_FLAG] = 1'b1;
        end
        if (rx_load) begin
            s_nxt.rx_data = rx_char_data[7:0];
            s_nxt.rx_full = 1'b1;
            // Flag changes only when a new byte reaches the holding register
            s_nxt.ctrl[B_FRAMING_ERROR_FLAG] = rx_char_frame_err;
            // Ninth bit passed through only with RX9 set, otherwise it reads zero; no parity check
            s_nxt.ctrl[B_NINTH_RECEIVED_BIT] = s_r.ctrl[B_RX9] & rx_char_data[8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r.ctrl <= CTRL_RST;
            s_r.rx_data <= '0;
            s_r.rx_full <= 1'b0;
            s_r.istat <= IRQ_RST;
            s_r.imask <= IRQ_RST;
            s_r.mode <= MODE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign serial_port_enable = s_r.ctrl[B_SERIAL_PORT_ENABLE];
    assign nine_bit_receive_select = s_r.ctrl[B_RX9];
    assign receive_run = rx_run;
    assign single_receive_active = s_r.ctrl[B_SERIAL_PORT_ENABLE] & single_receive_enable_eff & ~s_r.ctrl[B_OVERRUN_ERROR_FLAG];
    // Either receive enable in sync mode takes the line away from the transmitter
    assign rx_claims_line = sync_mode & (s_r.ctrl[B_SINGLE_RECEIVE_ENABLE] | s_r.ctrl[B_CONTINUOUS_RECEIVE_ENABLE]);
    assign transmit_run = s_r.ctrl[B_SERIAL_PORT_ENABLE] & s_r.mode[M_TRANSMIT_ENABLE] & ~rx_claims_line;
    assign irq = |(s_r.istat & s_r.imask);
endmodule : src_serial_receive_control
